// ==== verilog/wdw_pkg.sv ====
// Windowed watchdog constants, register map and carrier types
// Summary of operation
// - Counter runs from the 32 kHz low-power RC clock; enabling it enables the oscillator.
// - Prescaler divides by 32 or by 128, chosen by a configuration bit.
// - Prescaler period is 1 ms in 5-bit mode, 4 ms in 7-bit mode.
// - Postscaler ratio from a 4-bit field, 16 settings from 1:1 to 1:32768.
// - Completed clock switch, software or fail-safe forced, clears all counts.
// - Power-save instruction entering sleep or idle clears all counts.
// - Leaving sleep or idle for normal running clears all counts.
// - Clear instruction in normal running clears counter, prescaler and postscaler.
// - An enabled watchdog keeps counting in sleep and idle.
// - Timeout in sleep or idle wakes the core instead of resetting it.
// - Timeout flag stays set until software clears it.
// - Hard-enable configuration bit set keeps the watchdog always running.
// - With hard enable clear, the soft-enable bit starts and stops the watchdog.
// - Every device reset clears the soft-enable bit.
// - Windowed mode: an early clear causes an immediate watchdog reset.
`default_nettype none
package wdw_pkg;
    // Timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int RC_OSC_FREQ_HZ = 32_000;
    localparam int RC_OSC_DIV_CYCLES = CLK_FREQ_HZ / RC_OSC_FREQ_HZ;
    localparam int WD_BASE_PERIOD_5BIT_US = 1000;
    localparam int WD_BASE_PERIOD_7BIT_US = 4000;
    localparam logic [7:0] PRESC_DIV_5BIT = 8'(WD_BASE_PERIOD_5BIT_US * RC_OSC_FREQ_HZ / 1_000_000);
    localparam logic [7:0] PRESC_DIV_7BIT = 8'(WD_BASE_PERIOD_7BIT_US * RC_OSC_FREQ_HZ / 1_000_000);
    // Register byte addresses
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_RESET_CTRL = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    // Configuration word fields
    localparam int CFG_POST_LSB = 0;
    localparam int CFG_PRESC_BIT = 4;
    localparam int CFG_WIN_DIS_BIT = 6;
    localparam int CFG_HARD_EN_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Reset control register fields
    localparam int RC_IDLE_BIT = 2;
    localparam int RC_SLEEP_BIT = 3;
    localparam int RC_TIMEOUT_BIT = 4;
    localparam int RC_SOFT_EN_BIT = 5;
    // Count register fields
    localparam int CNT_PRESC_LSB = 0;
    localparam int CNT_POST_LSB = 16;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PM_RUN = 2'h0,
        PM_IDLE = 2'h1,
        PM_SLEEP = 2'h3
    } wdw_pmode_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } wdw_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wdw_axil_rsp_t;

    typedef struct packed {
        logic clear_wd_instr;
        logic power_save_instr;
        logic power_save_idle;
        logic osc_switch_done;
        logic wake_event;
    } wdw_core_evt_t;
endpackage
`default_nettype wire

// ==== verilog/wdw_watchdog.sv ====
// Windowed watchdog timer with AXI4-Lite register access
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module wdw_watchdog
    import wdw_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register bus
    input wire wdw_axil_req_t axil_in,
    output wdw_axil_rsp_t axil_out,
    // Core events and configuration word
    input wire wdw_core_evt_t core_evt_in,
    input wire logic [7:0] wd_config_word_in,
    // Watchdog actions
    output logic low_power_rc_osc_en_out,
    output logic wd_reset_req_out,
    output logic wake_req_out
);

    function automatic logic [15:0] post_ratio(input logic [3:0] sel);
        post_ratio = 16'h0001 << sel;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = (addr == ADDR_CONFIG) || (addr == ADDR_RESET_CTRL) || (addr == ADDR_COUNT);
    endfunction

    // State
    logic [7:0] cfg_ff;
    logic cfg_loaded_ff;
    logic [11:0] osc_div_cnt_ff;
    logic [11:0] nxt_osc_div_cnt;
    logic [6:0] presc_cnt_ff;
    logic [6:0] nxt_presc_cnt;
    logic [14:0] post_cnt_ff;
    logic [14:0] nxt_post_cnt;
    logic soft_en_ff;
    logic nxt_soft_en;
    logic timeout_flag_ff;
    logic nxt_timeout_flag;
    logic sleep_flag_ff;
    logic nxt_sleep_flag;
    logic idle_flag_ff;
    logic nxt_idle_flag;
    wdw_pmode_t pmode_ff;
    wdw_pmode_t nxt_pmode;
    logic wd_rst_ff;
    logic wake_ff;

    // Bus state
    logic aw_hold_ff;
    logic [7:0] awaddr_ff;
    logic w_hold_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Enables and clock divider
    wire hard_en = cfg_ff[CFG_HARD_EN_BIT];
    wire wd_enabled = hard_en | soft_en_ff;
    wire [3:0] post_sel = cfg_ff[CFG_POST_LSB +: 4];
    wire rc_tick = wd_enabled && (osc_div_cnt_ff == 12'(RC_OSC_DIV_CYCLES - 1));

    // Prescaler and postscaler terminal counts
    wire [7:0] presc_div = cfg_ff[CFG_PRESC_BIT] ? PRESC_DIV_7BIT : PRESC_DIV_5BIT;
    wire presc_last = rc_tick && ({1'b0, presc_cnt_ff} == presc_div - 8'h01);
    wire post_last = post_cnt_ff == 15'(post_ratio(post_sel) - 16'h0001);
    wire expire = presc_last && post_last;

    // Window position: elapsed ticks against three quarters of the period
    wire [22:0] elapsed = 23'({8'h00, post_cnt_ff} * {15'h0000, presc_div}) + 23'(presc_cnt_ff);
    wire [22:0] period = 23'({7'h00, post_ratio(post_sel)} * {15'h0000, presc_div});
    wire window_open = {elapsed, 2'b00} >= 25'({2'b00, period} * 25'h0000003);

    // Events
    wire in_run = pmode_ff == PM_RUN;
    wire run_clear = in_run & core_evt_in.clear_wd_instr;
    wire win_violation = wd_enabled & run_clear & ~cfg_ff[CFG_WIN_DIS_BIT] & ~window_open;
    // A clear landing on the expiry cycle wins, so no timeout then
    wire run_timeout = wd_enabled & in_run & expire & ~core_evt_in.clear_wd_instr;
    wire sleep_timeout = wd_enabled & ~in_run & expire;
    wire wd_device_rst = run_timeout | win_violation;
    wire enter_ps = in_run & core_evt_in.power_save_instr & ~wd_device_rst;
    wire exit_ps = ~in_run & (sleep_timeout | core_evt_in.wake_event);
    // Disabled watchdog holds its counts at zero so a later enable starts a full period
    wire cnt_clear = ~wd_enabled | run_clear | enter_ps | exit_ps | core_evt_in.osc_switch_done | wd_device_rst;

    // Register bus decode
    wire wr_fire = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire wr_rc = wr_fire && (awaddr_ff == ADDR_RESET_CTRL) && wstrb_ff[0];
    wire rd_fire = axil_in.arvalid & ~rvalid_ff;
    wire [31:0] rc_word = (32'(soft_en_ff) << RC_SOFT_EN_BIT) | (32'(timeout_flag_ff) << RC_TIMEOUT_BIT)
        | (32'(sleep_flag_ff) << RC_SLEEP_BIT) | (32'(idle_flag_ff) << RC_IDLE_BIT);
    wire [31:0] cnt_word = (32'(post_cnt_ff) << CNT_POST_LSB) | (32'(presc_cnt_ff) << CNT_PRESC_LSB);
    wire [31:0] rd_word = (axil_in.araddr == ADDR_CONFIG) ? {24'h000000, cfg_ff}
        : (axil_in.araddr == ADDR_RESET_CTRL) ? rc_word
        : (axil_in.araddr == ADDR_COUNT) ? cnt_word : 32'h00000000;

    // Counter next state
    always_comb begin
        nxt_osc_div_cnt = osc_div_cnt_ff;
        nxt_presc_cnt = presc_cnt_ff;
        nxt_post_cnt = post_cnt_ff;
        if (!wd_enabled || rc_tick) begin
            nxt_osc_div_cnt = 12'h000;
        end else begin
            nxt_osc_div_cnt = osc_div_cnt_ff + 12'h001;
        end
        // Clear events win over counting; counting runs in every power mode
        if (cnt_clear) begin
            nxt_presc_cnt = 7'h00;
            nxt_post_cnt = 15'h0000;
        end else if (presc_last) begin
            nxt_presc_cnt = 7'h00;
            nxt_post_cnt = post_last ? 15'h0000 : post_cnt_ff + 15'h0001;
        end else if (rc_tick) begin
            nxt_presc_cnt = presc_cnt_ff + 7'h01;
        end
    end

    // Status and enable next state
    always_comb begin
        nxt_soft_en = soft_en_ff;
        if (wd_device_rst) begin
            nxt_soft_en = 1'b0;
        end else if (wr_rc) begin
            nxt_soft_en = wdata_ff[RC_SOFT_EN_BIT];
        end
        // Hardware set wins over a software clear in the same cycle
        nxt_timeout_flag = (run_timeout | sleep_timeout | win_violation)
            | (timeout_flag_ff & ~(wr_rc & ~wdata_ff[RC_TIMEOUT_BIT]));
        nxt_sleep_flag = (enter_ps & ~core_evt_in.power_save_idle)
            | (sleep_flag_ff & ~(wr_rc & ~wdata_ff[RC_SLEEP_BIT]));
        nxt_idle_flag = (enter_ps & core_evt_in.power_save_idle)
            | (idle_flag_ff & ~(wr_rc & ~wdata_ff[RC_IDLE_BIT]));
    end

    // Power mode tracking
    always_comb begin
        nxt_pmode = pmode_ff;
        unique case (pmode_ff)
            PM_RUN: begin
                if (enter_ps) begin
                    nxt_pmode = core_evt_in.power_save_idle ? PM_IDLE : PM_SLEEP;
                end
            end
            PM_IDLE, PM_SLEEP: begin
                if (exit_ps) begin
                    nxt_pmode = PM_RUN;
                end
            end
            default: begin
                nxt_pmode = PM_RUN;
            end
        endcase
    end

    // Configuration word is a strap, caught once after reset release
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_ff <= CFG_RESET;
            cfg_loaded_ff <= 1'b0;
        end else if (!cfg_loaded_ff) begin
            cfg_ff <= wd_config_word_in;
            cfg_loaded_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            osc_div_cnt_ff <= 12'h000;
            presc_cnt_ff <= 7'h00;
            post_cnt_ff <= 15'h0000;
        end else begin
            osc_div_cnt_ff <= nxt_osc_div_cnt;
            presc_cnt_ff <= nxt_presc_cnt;
            post_cnt_ff <= nxt_post_cnt;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            soft_en_ff <= 1'b0;
            timeout_flag_ff <= 1'b0;
            sleep_flag_ff <= 1'b0;
            idle_flag_ff <= 1'b0;
        end else begin
            soft_en_ff <= nxt_soft_en;
            timeout_flag_ff <= nxt_timeout_flag;
            sleep_flag_ff <= nxt_sleep_flag;
            idle_flag_ff <= nxt_idle_flag;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pmode_ff <= PM_RUN;
            wd_rst_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            pmode_ff <= nxt_pmode;
            wd_rst_ff <= wd_device_rst;
            wake_ff <= sleep_timeout;
        end
    end

    // Write address and data are held until both have arrived
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            aw_hold_ff <= 1'b0;
            awaddr_ff <= 8'h00;
        end else if (axil_in.awvalid && !aw_hold_ff && !bvalid_ff) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= axil_in.awaddr;
        end else if (wr_fire) begin
            aw_hold_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            w_hold_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else if (axil_in.wvalid && !w_hold_ff && !bvalid_ff) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= axil_in.wdata;
            wstrb_ff <= axil_in.wstrb;
        end else if (wr_fire) begin
            w_hold_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= addr_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (axil_in.bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= addr_mapped(axil_in.araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (axil_in.rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Outputs
    assign axil_out = '{
        awready: ~aw_hold_ff & ~bvalid_ff,
        wready: ~w_hold_ff & ~bvalid_ff,
        bvalid: bvalid_ff,
        bresp: bresp_ff,
        arready: ~rvalid_ff,
        rvalid: rvalid_ff,
        rdata: rdata_ff,
        rresp: rresp_ff
    };
    assign low_power_rc_osc_en_out = wd_enabled;
    assign wd_reset_req_out = wd_rst_ff;
    assign wake_req_out = wake_ff;

endmodule
`default_nettype wire

// ==== bench/wdw_watchdog_checker.sv ====
// Port-level assertions for the windowed watchdog
`timescale 1ns/100ps
`default_nettype none
module wdw_watchdog_checker
    import wdw_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Bus, events and configuration
    input wire wdw_axil_req_t axil_in,
    input wire wdw_axil_rsp_t axil_out,
    input wire wdw_core_evt_t core_evt_in,
    input wire logic [7:0] wd_config_word_in,
    // Watchdog actions
    input wire logic low_power_rc_osc_en_out,
    input wire logic wd_reset_req_out,
    input wire logic wake_req_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence wr_taken;
        axil_in.awvalid && axil_out.awready && axil_in.wvalid && axil_out.wready;
    endsequence
    sequence rd_taken;
        axil_in.arvalid && axil_out.arready;
    endsequence
    write_answer_a: assert property (wr_taken |-> ##2 axil_out.bvalid) else $error("write response late");
    read_answer_a: assert property (rd_taken |=> axil_out.rvalid) else $error("read response late");
    bresp_hold_a: assert property (axil_out.bvalid && !axil_in.bready |=> axil_out.bvalid && $stable(axil_out.bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (axil_out.rvalid && !axil_in.rready |=> axil_out.rvalid && $stable(axil_out.rdata))
        else $error("read data dropped");
    ar_refuse_a: assert property (axil_out.arready == !axil_out.rvalid) else $error("read address ready wrong");
    reset_pulse_a: assert property (wd_reset_req_out |=> !wd_reset_req_out) else $error("reset request too long");
    wake_pulse_a: assert property (wake_req_out |=> !wake_req_out) else $error("wake request too long");
    wake_no_reset_a: assert property (!(wake_req_out && wd_reset_req_out)) else $error("wake with reset");
    hard_enable_a: assert property (wd_config_word_in[CFG_HARD_EN_BIT] [*4] |-> low_power_rc_osc_en_out)
        else $error("hard enable not running");
    idle_quiet_a: assert property (!low_power_rc_osc_en_out [*3] |-> !wd_reset_req_out && !wake_req_out)
        else $error("disabled watchdog acted");
    clear_no_reset_a: assert property (core_evt_in.clear_wd_instr && wd_config_word_in[CFG_WIN_DIS_BIT]
        |=> !wd_reset_req_out) else $error("reset after clear");
endmodule
bind wdw_watchdog wdw_watchdog_checker wdw_watchdog_checker_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .axil_in(axil_in), .axil_out(axil_out), .core_evt_in(core_evt_in), .wd_config_word_in(wd_config_word_in),
    .low_power_rc_osc_en_out(low_power_rc_osc_en_out), .wd_reset_req_out(wd_reset_req_out),
    .wake_req_out(wake_req_out));
`default_nettype wire

// ==== bench/tb_wdw_watchdog.sv ====
// Self-checking bench for the windowed watchdog
`timescale 1ns/100ps
`default_nettype none
module tb_wdw_watchdog
    import wdw_pkg::*;
;
    logic clk_in;
    logic sys_rst_in;
    wdw_axil_req_t req;
    wdw_axil_rsp_t rsp;
    wdw_core_evt_t evt;
    logic [7:0] cfg;
    logic osc_en;
    logic rst_req;
    logic wake_req;
    int fails;
    int n_tests;
    int n;
    logic seen;
    logic [31:0] d;

    wdw_watchdog wdw_watchdog_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .axil_in(req), .axil_out(rsp),
        .core_evt_in(evt), .wd_config_word_in(cfg), .low_power_rc_osc_en_out(osc_en),
        .wd_reset_req_out(rst_req), .wake_req_out(wake_req));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task timed_out(input string what);
        fails++;
        $display("wrong value %s expected answer seen none", what);
        end_of_test();
    endtask

    // Master offers address and data together, holds bready until answered
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int k;
        @(posedge clk_in);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && k < 50);
        if (k >= 50) timed_out("write response");
        check("write response", 32'(rsp.bresp), 32'(er));
        req.bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] m, input logic [1:0] er, input string what);
        int k;
        @(posedge clk_in);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && k < 50);
        if (k >= 50) timed_out("read response");
        d = rsp.rdata;
        check(what, d & m, ev);
        check("read response", 32'(rsp.rresp), 32'(er));
        req.rready <= 1'b0;
    endtask

    // Bits: clear, power save, idle, clock switch, wake
    task pulse(input logic [4:0] e);
        @(posedge clk_in);
        evt <= wdw_core_evt_t'(e);
        @(posedge clk_in);
        evt <= '0;
    endtask

    task do_reset(input logic [7:0] c);
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        cfg <= c;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
    endtask

    initial begin
        sys_rst_in = 1'b1;
        req = '0;
        evt = '0;
        cfg = 8'h40;
        fails = 0;
        n_tests = 0;
        do_reset(8'h40);
        rd(ADDR_CONFIG, 32'h40, 32'hffffffff, RESP_OKAY, "config word");
        rd(ADDR_RESET_CTRL, 32'h0, 32'hffffffff, RESP_OKAY, "reset control");
        rd(8'h0c, 32'h0, 32'hffffffff, RESP_SLVERR, "unmapped read");
        wr(8'h0c, 32'h20, RESP_SLVERR);
        repeat (3200) @(posedge clk_in);
        rd(ADDR_COUNT, 32'h0, 32'hffffffff, RESP_OKAY, "count disabled");
        check("osc enable off", 32'(osc_en), 32'h1 ^ 32'h1);
        $display("test reset and decode done");
        wr(ADDR_RESET_CTRL, 32'h20, RESP_OKAY);
        check("osc enable on", 32'(osc_en), 32'h1);
        repeat (7000) @(posedge clk_in);
        rd(ADDR_COUNT, 32'h0, 32'h0, RESP_OKAY, "count");
        check("prescale count", 32'(d[6:0] inside {7'h2, 7'h3}), 32'h1);
        pulse(5'h10);
        rd(ADDR_COUNT, 32'h0, 32'hffffffff, RESP_OKAY, "count after clear");
        repeat (3200) @(posedge clk_in);
        pulse(5'h02);
        rd(ADDR_COUNT, 32'h0, 32'hffffffff, RESP_OKAY, "count after switch");
        $display("test soft enable and clears done");
        pulse(5'h0c);
        rd(ADDR_COUNT, 32'h0, 32'hffffffff, RESP_OKAY, "count at idle entry");
        rd(ADDR_RESET_CTRL, 32'h24, 32'hffffffff, RESP_OKAY, "idle status");
        repeat (3300) @(posedge clk_in);
        rd(ADDR_COUNT, 32'h0, 32'h0, RESP_OKAY, "count");
        check("count in idle", 32'(d[6:0] != 7'h0), 32'h1);
        pulse(5'h01);
        rd(ADDR_COUNT, 32'h0, 32'hffffffff, RESP_OKAY, "count after wake");
        wr(ADDR_RESET_CTRL, 32'h20, RESP_OKAY);
        rd(ADDR_RESET_CTRL, 32'h20, 32'hffffffff, RESP_OKAY, "status cleared");
        // Sleep timeout: 32 ticks of 3125 cycles, tick phase may take off up to one tick
        pulse(5'h08);
        n = 0;
        seen = 1'b0;
        while (wake_req !== 1'b1 && n < 110000) begin
            @(posedge clk_in);
            n++;
            if (rst_req === 1'b1) seen = 1'b1;
        end
        check("sleep timeout window", 32'(n >= 96870 && n <= 103130), 32'h1);
        check("reset during sleep", 32'(seen), 32'h0);
        rd(ADDR_RESET_CTRL, 32'h38, 32'hffffffff, RESP_OKAY, "flag after wake");
        wr(ADDR_RESET_CTRL, 32'h20, RESP_OKAY);
        rd(ADDR_RESET_CTRL, 32'h20, 32'hffffffff, RESP_OKAY, "flag cleared");
        $display("test power save done");
        do_reset(8'h80);
        rd(ADDR_RESET_CTRL, 32'h0, 32'hffffffff, RESP_OKAY, "soft enable after reset");
        check("hard enable running", 32'(osc_en), 32'h1);
        wr(ADDR_RESET_CTRL, 32'h0, RESP_OKAY);
        check("hard enable kept", 32'(osc_en), 32'h1);
        pulse(5'h10);
        n = 0;
        while (rst_req !== 1'b1 && n < 20) begin
            @(posedge clk_in);
            n++;
        end
        check("early clear reset", 32'(rst_req === 1'b1), 32'h1);
        rd(ADDR_RESET_CTRL, 32'h10, 32'hffffffff, RESP_OKAY, "flag after early clear");
        $display("test hard enable and window done");
        end_of_test();
    end
endmodule
`default_nettype wire
